/* dv/etc_pin_src.sv */
/* pulse source on the counter pin: one high then low phase per request.
   assumes a one-cycle request; the pin rests low between pulses. */
`timescale 1ns/1ns
module etc_pin_src (
   input wire i_clk,
   input wire i_go,
   input wire [7:0] i_len,
   output wire o_pin
);
   reg [8:0] cnt_reg = 9'h000;
   assign o_pin = cnt_reg > {1'b0, i_len};
   always @(posedge i_clk)
      cnt_reg <= i_go ? {i_len, 1'b0} : cnt_reg - {8'h00, cnt_reg != 9'h000};
endmodule

/* dv/etc_timer_props.sv */
/* port checker for the timer block.
   assumes one clock domain and the single-cycle register port. */
`timescale 1ns/1ns
module etc_timer_props (
   input wire i_core_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_halted,
   input wire [7:0] o_rdata,
   input wire o_irq,
   input wire o_wake,
   input wire o_freq_divider_output,
   input wire o_buzzer_drive,
   input wire o_buzzer_drive_n
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   ctrl_bit_five_a: assert property ($past(i_rd) && $past(i_addr) == 8'h0E |-> !o_rdata[5])
      else $error("unused control bit set");
   unmapped_read_a: assert property ($past(i_rd) && !($past(i_addr) inside {8'h0B, 8'h0D, 8'h0E, 8'h14})
      |-> o_rdata == 8'h00) else $error("unmapped read not zero");
   buzz_pair_a: assert property (o_buzzer_drive |-> !o_buzzer_drive_n)
      else $error("buzzer pair not opposite");
   buzz_follow_a: assert property (o_buzzer_drive || o_buzzer_drive_n |-> o_buzzer_drive == o_freq_divider_output)
      else $error("buzzer not following divider");
   wake_cause_a: assert property (o_wake == ($changed(o_freq_divider_output) && $past(i_halted)))
      else $error("wake pulse without halted overflow");
   wake_pulse_a: assert property (o_wake |=> !o_wake)
      else $error("wake pulse too long");
   pfd_spacing_a: assert property ($changed(o_freq_divider_output) |=> $stable(o_freq_divider_output))
      else $error("divider toggled twice in a row");
   irq_mask_a: assert property ((i_wr && i_addr == 8'h0B && !i_wdata[3]) ##1 !(i_wr && i_addr == 8'h0B)
      |=> !o_irq) else $error("irq while masked");
   cover property (o_wake);
   cover property ($changed(o_freq_divider_output));
   cover property ($rose(o_irq));
endmodule
bind etc_timer etc_timer_props u_props (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_halted,
   .o_rdata, .o_irq, .o_wake, .o_freq_divider_output, .o_buzzer_drive, .o_buzzer_drive_n);

/* dv/etc_timer_tb_top.sv */
/* bench for the timer block: register tasks, pin source, expected values.
   assumes the checker binds itself onto the design. */
`timescale 1ns/1ns
module etc_timer_tb_top;
   reg i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_halted = 1'b0, go = 1'b0, woke = 1'b0;
   reg [7:0] i_addr = 8'h00, i_wdata = 8'h00, len = 8'h08, v;
   wire pin, o_irq, o_wake, freq_divider_output;
   wire [7:0] o_rdata;
   integer fails = 0, checks = 0, i, n, p;
   always #5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) if (o_wake) woke <= 1'b1;
   etc_pin_src src (.i_clk(i_core_clk), .i_go(go), .i_len(len), .o_pin(pin));
   etc_timer uut (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_event_pin(pin),
      .i_rtc_tick(1'b0), .i_halted, .o_irq, .o_wake, .o_freq_divider_output(freq_divider_output), .o_buzzer_drive(),
      .o_buzzer_drive_n());
   task end_sim;
   begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   end
   endtask
   task rc(input [63:0] nm, input [7:0] a, input [7:0] e);
   begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
      chk(nm, e, v);
   end
   endtask
   // cycles until the divider output moves; capped so a dead timer cannot hang
   task tw;
      reg s;
   begin
      s = freq_divider_output;
      n = 0;
      while (freq_divider_output === s && n < 600)
      begin
         @(posedge i_core_clk);
         #1 n = n + 1;
      end
   end
   endtask
   task pulse;
   begin
      @(posedge i_core_clk);
      go <= 1'b1;
      @(posedge i_core_clk);
      go <= 1'b0;
      repeat (2 * len + 6) @(posedge i_core_clk);
   end
   endtask
   initial
   begin
      #300000;
      fails = fails + 1;
      end_sim;
   end
   initial
   begin
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rc("ctrl", 8'h0E, 8'h08);
      rc("unmap", 8'h30, 8'h00);
      wr(8'h0E, 8'hFF);
      rc("ctrl", 8'h0E, 8'hDF);
      wr(8'h0E, 8'h00);
      wr(8'h0D, 8'hA5);
      rc("count", 8'h0D, 8'hA5);
      $display("register test done");
      for (p = 0; p < 8; p = p + 1)
      begin
         wr(8'h0E, 8'h00);
         wr(8'h0D, 8'hFF);
         wr(8'h0B, 8'h00);
         wr(8'h0E, 8'h90 | p[7:0]);
         tw;
         tw;
         chk("period", 16'h0002 << p, n[15:0]);
         rc("ctrl", 8'h0E, 8'h90 | p[7:0]);
         wr(8'h0E, 8'h00);
         rc("interrupt_control", 8'h0B, 8'h20);
      end
      wr(8'h0B, 8'h28);
      repeat (3) @(posedge i_core_clk);
      #1 chk("irq", 1, o_irq);
      wr(8'h0B, 8'h20);
      repeat (3) @(posedge i_core_clk);
      #1 chk("irq", 0, o_irq);
      $display("timer test done");
      wr(8'h0D, 8'hFA);
      wr(8'h0E, 8'h50);
      for (i = 0; i < 3; i = i + 1) pulse;
      rc("count", 8'h0D, 8'hFD);
      wr(8'h0D, 8'h10);
      rc("running", 8'h0D, 8'hFD);
      i_halted <= 1'b1;
      for (i = 0; i < 6; i = i + 1) pulse;
      rc("count", 8'h0D, 8'h13);
      chk("wake", 1, woke);
      i_halted <= 1'b0;
      wr(8'h0E, 8'h58);
      pulse;
      rc("fall", 8'h0D, 8'h14);
      $display("event test done");
      wr(8'h0E, 8'h00);
      wr(8'h0D, 8'h00);
      wr(8'h0E, 8'hD0);
      len <= 8'd40;
      pulse;
      rc("ctrl", 8'h0E, 8'hC0);
      rc("width", 8'h0D, 8'h14);
      chk("width", 1, v >= 8'd19 && v <= 8'd21);
      chk("width", 1, v >= 8'd19 && v <= 8'd21);
      pulse;
      rc("hold", 8'h0D, v);
      $display("pulse test done");
      end_sim;
   end
endmodule

/* rtl/etc_defines.vh */
/*
 defines for the 8-bit timer/event counter: register offsets, control field
 positions, reset values and mode codes. assumes inclusion by bare name.
*/
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
`define ETC_ADDR_COUNT 8'h0D
`define ETC_ADDR_CTRL 8'h0E
`define ETC_ADDR_INTERRUPT_CONTROL 8'h0B
`define ETC_ADDR_PORTB 8'h14
`define ETC_CTRL_PSC_LSB 0
`define ETC_CTRL_PSC_MSB 2
`define ETC_CTRL_EDGE 3
`define ETC_CTRL_RUN 4
`define ETC_CTRL_MODE_LSB 6
`define ETC_CTRL_MODE_MSB 7
`define ETC_INTERRUPT_CONTROL_ENABLE 3
`define ETC_INTERRUPT_CONTROL_FLAG 5
`define ETC_CTRL_RESET 8'h08
`define ETC_CTRL_MASK 8'hDF
`define ETC_INTERRUPT_CONTROL_MASK 8'h28
`define ETC_MODE_EVENT 2'h1
`define ETC_MODE_TIMER 2'h2
`define ETC_MODE_PULSE 2'h3
`endif

/* rtl/etc_timer.v */
/*
 8-bit timer/event counter with preload, prescaler, pulse-width mode,
 overflow flag, wake-up pulse and buzzer divider output.
 assumes a single-cycle register port master and an asynchronous event pin.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "etc_defines.vh"
module etc_timer #(
   parameter USE_RTC = 0,
   parameter BUZZER_EN = 1
)(
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // register port
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // pins and sources
   input wire i_event_pin,
   input wire i_rtc_tick,
   input wire i_halted,
   // outputs
   output reg o_irq,
   output reg o_wake,
   output reg o_freq_divider_output,
   output reg o_buzzer_drive,
   output reg o_buzzer_drive_n
);
   reg [7:0] count_reg;
   reg [7:0] preload_reg;
   reg [7:0] ctrl_reg;
   reg flag_reg;
   reg ie_reg;
   reg pb0_data_reg;
   reg [2:0] pin_sync_reg;
   reg [2:0] rtc_sync_reg;
   reg pin_level_reg;
   reg rtc_level_reg;
   reg [7:0] psc_reg;
   reg measuring_reg;
   reg start_level_reg;
   reg [7:0] psc_next;
   wire [1:0] mode;
   wire pin_now;
   wire pin_edge;
   wire active_edge;
   wire src_tick;
   wire fint_tick;
   wire run;
   wire count_tick;
   wire overflow;
   wire sel_count;
   wire sel_ctrl;
   wire sel_interrupt_control;
   wire [2:0] psc_sel;

   assign mode = ctrl_reg[`ETC_CTRL_MODE_MSB:`ETC_CTRL_MODE_LSB];
   assign run = ctrl_reg[`ETC_CTRL_RUN];
   assign psc_sel = ctrl_reg[`ETC_CTRL_PSC_MSB:`ETC_CTRL_PSC_LSB];
   assign sel_count = (i_addr == `ETC_ADDR_COUNT);
   assign sel_ctrl = (i_addr == `ETC_ADDR_CTRL);
   assign sel_interrupt_control = (i_addr == `ETC_ADDR_INTERRUPT_CONTROL);

   // change accepted once stages two and three agree
   assign pin_now = (pin_sync_reg[1] == pin_sync_reg[2]) ? pin_sync_reg[2] : pin_level_reg;
   assign pin_edge = pin_now != pin_level_reg;
   assign active_edge = pin_edge & (ctrl_reg[`ETC_CTRL_EDGE] ? ~pin_now : pin_now);

   assign src_tick = (USE_RTC != 0) ?
      ((rtc_sync_reg[1] == rtc_sync_reg[2]) & rtc_sync_reg[2] & ~rtc_level_reg) : 1'b1;

   // divisor 2^(sel+1): tick when the low sel+1 bits wrap
   always @*
   begin
      psc_next = psc_reg;
      if (src_tick)
      begin
         psc_next = psc_reg + 8'h01;
      end
   end
   assign fint_tick = src_tick & (((psc_reg | ~(8'hFF >> (3'h7 - psc_sel))) ) == 8'hFF);

   // reads stall the count for one cycle so the captured value is stable
   assign count_tick = run & ~i_rd &
      (((mode == `ETC_MODE_EVENT) & active_edge) |
       ((mode == `ETC_MODE_TIMER) & fint_tick) |
       ((mode == `ETC_MODE_PULSE) & measuring_reg & fint_tick));
   assign overflow = count_tick & (count_reg == 8'hFF);

   // first stage may be metastable; only the shift reads it
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_sync_reg <= 3'h0;
      end
      else
      begin
         pin_sync_reg <= {pin_sync_reg[1:0], i_event_pin};
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rtc_sync_reg <= 3'h0;
      end
      else
      begin
         rtc_sync_reg <= {rtc_sync_reg[1:0], i_rtc_tick};
      end
   end

   // accepted pin level; idle low after reset so no false edge
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_level_reg <= 1'b0;
      end
      else
      begin
         pin_level_reg <= pin_now;
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rtc_level_reg <= 1'b0;
      end
      else
      begin
         if (rtc_sync_reg[1] == rtc_sync_reg[2])
         begin
            rtc_level_reg <= rtc_sync_reg[2];
         end
      end
   end

   // prescaler cleared while stopped so each start has a full period
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         psc_reg <= 8'h00;
      end
      else
      begin
         psc_reg <= run ? psc_next : 8'h00;
      end
   end

   // live counter; tick and software load never meet since load needs run low
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         count_reg <= 8'h00;
      end
      else
      begin
         if (count_tick)
         begin
            count_reg <= overflow ? preload_reg : count_reg + 8'h01;
         end
         if (i_wr & sel_count)
         begin
            if (!run)
            begin
               count_reg <= i_wdata;
            end
         end
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         preload_reg <= 8'h00;
      end
      else
      begin
         if (i_wr & sel_count)
         begin
            preload_reg <= i_wdata;
         end
      end
   end

   // control, plus the single-shot measurement state it arms
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_reg <= `ETC_CTRL_RESET;
         measuring_reg <= 1'b0;
         start_level_reg <= 1'b0;
      end
      else
      begin
         if (i_wr & sel_ctrl)
         begin
            ctrl_reg <= i_wdata & `ETC_CTRL_MASK;
            measuring_reg <= 1'b0;
         end
         else if ((mode == `ETC_MODE_PULSE) & run)
         begin
            if (!measuring_reg & active_edge)
            begin
               measuring_reg <= 1'b1;
               start_level_reg <= pin_level_reg;
            end
            else if (measuring_reg & pin_edge & (pin_now == start_level_reg))
            begin
               measuring_reg <= 1'b0;
               ctrl_reg[`ETC_CTRL_RUN] <= 1'b0;
            end
         end
         // other modes leave the enable to software
      end
   end

   // overflow in the same cycle as a software clear wins
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         flag_reg <= 1'b0;
      end
      else
      begin
         if (i_wr & sel_interrupt_control)
         begin
            flag_reg <= i_wdata[`ETC_INTERRUPT_CONTROL_FLAG] | overflow;
         end
         else if (overflow)
         begin
            flag_reg <= 1'b1;
         end
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ie_reg <= 1'b0;
      end
      else
      begin
         if (i_wr & sel_interrupt_control)
         begin
            ie_reg <= i_wdata[`ETC_INTERRUPT_CONTROL_ENABLE];
         end
      end
   end

   // only bit zero of the port latch matters here: it gates the buzzer
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pb0_data_reg <= 1'b1;
      end
      else
      begin
         if (i_wr & (i_addr == `ETC_ADDR_PORTB))
         begin
            pb0_data_reg <= i_wdata[0];
         end
      end
   end

   // read data stand one cycle, zero otherwise
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata <= 8'h00;
      end
      else
      begin
         o_rdata <= 8'h00;
         if (i_rd)
         begin
            case (i_addr)
               `ETC_ADDR_COUNT:
               begin
                  o_rdata <= count_reg;
               end
               `ETC_ADDR_CTRL:
               begin
                  o_rdata <= ctrl_reg;
               end
               `ETC_ADDR_INTERRUPT_CONTROL:
               begin
                  o_rdata <= {2'h0, flag_reg, 1'b0, ie_reg, 3'h0};
               end
               default:
               begin
                  o_rdata <= 8'h00;
               end
            endcase
         end
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= flag_reg & ie_reg;
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_wake <= 1'b0;
      end
      else
      begin
         o_wake <= overflow & i_halted;
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_freq_divider_output <= 1'b0;
      end
      else
      begin
         if (overflow)
         begin
            o_freq_divider_output <= ~o_freq_divider_output;
         end
      end
   end

   // pair follows the divider's next level so it matches in the same cycle
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_buzzer_drive <= 1'b0;
      end
      else
      begin
         o_buzzer_drive <= (BUZZER_EN != 0) & pb0_data_reg &
            (overflow ^ o_freq_divider_output);
      end
   end

   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_buzzer_drive_n <= 1'b0;
      end
      else
      begin
         o_buzzer_drive_n <= (BUZZER_EN != 0) & pb0_data_reg &
            ~(overflow ^ o_freq_divider_output);
      end
   end

endmodule
